// ===== hdl/bcem_pkg.sv
// Package for the bus and core event monitor: register map, field layout,
// reset values, event codes, unit masks and the event-source carriers.
// Assumes a single clock domain; bus-side events arrive already qualified
// by a one-cycle bus clock tick from the bus unit.
package bcem_pkg;

  // ---------------------------------------------------------------------
  // Counters
  // ---------------------------------------------------------------------
  localparam int NUM_CNT = 4;
  localparam int FIRST_CNT = 4;
  localparam int PEND_CNT_LIMIT = 2;
  localparam int SNOOPQ_DEPTH = 8;
  localparam logic [1:0] PENDING_MAX = 2'h3;

  // ---------------------------------------------------------------------
  // Event codes
  // ---------------------------------------------------------------------
  localparam logic [7:0] EV_INVAL_MODHIT = 8'h42;
  localparam logic [7:0] EV_BURST_RFO_MODHIT = 8'h43;
  localparam logic [7:0] EV_IO_READ = 8'h51;
  localparam logic [7:0] EV_PARTIAL_READ = 8'h4D;
  localparam logic [7:0] EV_SNOOP_TOTAL = 8'h46;
  localparam logic [7:0] EV_SNOOP_MODHIT = 8'h45;
  localparam logic [7:0] EV_SNOOP_STALL = 8'h55;
  localparam logic [7:0] EV_SNOOP_PENDING = 8'h56;
  localparam logic [7:0] EV_LINE_WRITEBACK = 8'h52;
  localparam logic [7:0] EV_PRIVILEGE_CHANGE = 8'h34;
  localparam logic [7:0] EV_CPU_CYCLES = 8'h12;
  localparam logic [7:0] EV_DATA_ACCESS = 8'h03;
  localparam logic [7:0] EV_DATA_CAPTURE = 8'h67;
  localparam logic [7:0] EV_DATA_REFS = 8'h63;
  localparam logic [7:0] EV_DEPENDENCY = 8'h06;

  localparam logic [3:0] UMASK_ANY = 4'h0;
  localparam logic [3:0] UMASK_SELF = 4'h1;

  // ---------------------------------------------------------------------
  // Register map and fields
  // ---------------------------------------------------------------------
  localparam logic [7:0] CFG_BASE = 8'h00;
  localparam logic [7:0] CNT_BASE = 8'h10;
  localparam logic [7:0] STATUS_OFF = 8'h20;
  localparam int CFG_CODE_LSB = 0;
  localparam int CFG_UMASK_LSB = 8;
  localparam int CFG_EN_BIT = 16;
  localparam logic [31:0] CFG_MASK = 32'h0001_0FFF;
  localparam int STAT_PRIV_LSB = 0;
  localparam int STAT_PEND_LSB = 8;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [31:0] CNT_RST = 32'h0000_0000;
  localparam logic [1:0] PRIV_RST = 2'h0;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // ---------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------
  typedef enum logic [2:0] {
    TXN_OTHER, TXN_LINE_INVAL, TXN_BURST_OWN, TXN_IO_READ, TXN_PARTIAL_READ, TXN_BURST_WRITE
  } bcem_txn_kind_t;

  typedef struct packed {
    logic txn_valid;
    bcem_txn_kind_t txn_kind;
    logic txn_self;
    logic txn_modhit;
    logic txn_wb_src;
    logic snoop_valid;
    logic snoop_modhit;
    logic bus_tick;
    logic snoop_stall;
    logic stall_local;
    logic [SNOOPQ_DEPTH-1:0] sq_valid;
    logic [SNOOPQ_DEPTH-1:0] sq_snoop_done;
  } bcem_fsb_ev_t;

  typedef struct packed {
    logic [1:0] priv_level;
    logic dcache_miss;
    logic way_mispredict;
    logic xlate_miss;
    logic capture_evt;
    logic [1:0] ref_valid;
    logic [1:0] ref_pred_on;
    logic sb_int;
    logic sb_fp;
    logic disp_stop;
    logic fp_flush;
    logic creg_delay;
    logic mem_wait;
  } bcem_core_ev_t;

  typedef struct packed {
    logic en;
    logic [3:0] umask;
    logic [7:0] code;
  } bcem_cfg_t;

endpackage

// ===== hdl/bcem_monitor.sv
// Event monitor: four event counters behind an AHB-Lite slave.
// Assumes event inputs come from logic on the same clock (no synchronisers)
// and that every event pulse lasts one cycle per occurrence.
//
// Functional notes
// [R01] 0x42: own line-invalidate with modified hit
// [R02] 0x43: own burst-read-own with modified hit
// [R03] 0x51: I/O reads, Any or Self only
// [R04] 0x4d: partial reads, one per cycle
// [R05] 0x46: all internal snoops, Any only
// [R06] 0x45: snoops hitting local modified line
// [R07] 0x55: bus clocks stalled by snoop stall
// [R08] Self: local stalls; Any: all stalls
// [R09] 0x56: pending snoops, up to 3, counters 4-5
// [R10] Exclude queue entries past snoop phase
// [R11] 0x52: write-back line transactions
// [R12] 0x34: privilege level changes
// [R13] 0x12: every processor cycle
// [R14] 0x03: data-wait stall or flush cycles
// [R15] 0x67: data capture register events
// [R16] 0x63: retired data references, up to 2
// [R17] 0x06: dependency stalls, excluding memory waits
// [R18] Bus events unqualified; counters 4 to 7
// [R19] Add increment each cycle; unknown codes zero
//
// Our own choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps

module bcem_monitor
  import bcem_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire bcem_fsb_ev_t fsb_ev,
  input wire bcem_core_ev_t core_ev
);

  // ---------------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------------
  logic addr_ok;
  logic take_wr;
  logic take_rd;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic [31:0] next_rdata;
  bcem_cfg_t cfg [NUM_CNT];
  logic [31:0] cnt [NUM_CNT];
  logic [1:0] inc [NUM_CNT];
  logic [1:0] priv_prev;
  logic priv_seen;
  logic [1:0] pending;

  assign addr_ok = (haddr[31:8] == 24'h0) && (haddr[1:0] == 2'h0);
  assign take_wr = hsel && htrans[1] && hready && hwrite && addr_ok && (hsize == HSIZE_WORD);
  assign take_rd = hsel && htrans[1] && hready && !hwrite;

  // The slave never inserts wait states and never errors.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= take_wr;
      wr_addr <= haddr[7:0];
    end
  end

  // Read data is registered at the address phase, so a read right behind a
  // write to the same config or counter register takes the write data by bypass.
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (take_rd && addr_ok) begin
      for (int k = 0; k < NUM_CNT; k++) begin
        if (haddr[7:0] == CFG_BASE + 8'(4 * k)) begin
          if (wr_pend && wr_addr == haddr[7:0]) begin
            next_rdata = hwdata & CFG_MASK;
          end else begin
            next_rdata = 32'({cfg[k].en, 4'h0, cfg[k].umask, cfg[k].code});
          end
        end
        if (haddr[7:0] == CNT_BASE + 8'(4 * k)) begin
          if (wr_pend && wr_addr == haddr[7:0]) begin
            next_rdata = hwdata;
          end else begin
            next_rdata = cnt[k];
          end
        end
      end
      if (haddr[7:0] == STATUS_OFF) begin
        next_rdata[STAT_PRIV_LSB +: 2] = priv_prev;
        next_rdata[STAT_PEND_LSB +: 2] = pending;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hrdata <= 32'h0000_0000;
    end else if (take_rd) begin
      hrdata <= next_rdata;
    end
  end

  // ---------------------------------------------------------------------
  // Event sources
  // ---------------------------------------------------------------------
  logic ev_inval_modhit;
  logic ev_rfo_modhit;
  logic ev_io_any;
  logic ev_io_self;
  logic ev_partial;
  logic ev_snoop;
  logic ev_snoop_hit;
  logic ev_stall_any;
  logic ev_stall_self;
  logic ev_writeback;
  logic ev_priv;
  logic ev_data_stall;
  logic [1:0] ev_refs;
  logic ev_dep;
  logic [3:0] sq_open;

  assign ev_inval_modhit = fsb_ev.txn_valid && fsb_ev.txn_kind == TXN_LINE_INVAL
                           && fsb_ev.txn_self && fsb_ev.txn_modhit; // [R01]
  assign ev_rfo_modhit = fsb_ev.txn_valid && fsb_ev.txn_kind == TXN_BURST_OWN
                         && fsb_ev.txn_self && fsb_ev.txn_modhit; // [R02]
  assign ev_io_any = fsb_ev.txn_valid && fsb_ev.txn_kind == TXN_IO_READ; // [R03]
  assign ev_io_self = ev_io_any && fsb_ev.txn_self; // [R03]
  assign ev_partial = fsb_ev.txn_valid && fsb_ev.txn_kind == TXN_PARTIAL_READ; // [R04]
  assign ev_snoop = fsb_ev.snoop_valid; // [R05]
  assign ev_snoop_hit = fsb_ev.snoop_valid && fsb_ev.snoop_modhit; // [R06]
  assign ev_stall_any = fsb_ev.bus_tick && fsb_ev.snoop_stall; // [R07]
  assign ev_stall_self = ev_stall_any && fsb_ev.stall_local; // [R08]
  assign ev_writeback = fsb_ev.txn_valid && fsb_ev.txn_kind == TXN_BURST_WRITE
                        && fsb_ev.txn_wb_src; // [R11]
  assign ev_data_stall = core_ev.dcache_miss || core_ev.way_mispredict || core_ev.xlate_miss; // [R14]
  assign ev_refs = 2'({1'b0, core_ev.ref_valid[0] & core_ev.ref_pred_on[0]})
                   + 2'({1'b0, core_ev.ref_valid[1] & core_ev.ref_pred_on[1]}); // [R16]
  assign ev_dep = (core_ev.sb_int || core_ev.sb_fp || core_ev.disp_stop || core_ev.fp_flush
                   || core_ev.creg_delay) && !core_ev.mem_wait; // [R17]

  // Entries held past their snoop phase are left out of the count.
  always_comb begin
    sq_open = 4'h0;
    for (int k = 0; k < SNOOPQ_DEPTH; k++) begin
      sq_open = sq_open + 4'({3'h0, fsb_ev.sq_valid[k] & !fsb_ev.sq_snoop_done[k]}); // [R10]
    end
  end

  assign pending = (sq_open > 4'({2'h0, PENDING_MAX})) ? PENDING_MAX : sq_open[1:0]; // [R09]

  // The first sample after reset only primes the history, so a nonzero
  // level at start is not taken for a change.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      priv_prev <= PRIV_RST;
      priv_seen <= 1'b0;
    end else begin
      priv_prev <= core_ev.priv_level;
      priv_seen <= 1'b1;
    end
  end

  assign ev_priv = priv_seen && (core_ev.priv_level != priv_prev); // [R12]

  // ---------------------------------------------------------------------
  // Counters
  // ---------------------------------------------------------------------
  // Address range and opcode qualifiers are not wired to bus events at all.
  for (genvar i = 0; i < NUM_CNT; i++) begin : g_cnt
    always_comb begin
      inc[i] = 2'h0;
      case (cfg[i].code)
        EV_INVAL_MODHIT: inc[i] = {1'b0, ev_inval_modhit}; // [R01]
        EV_BURST_RFO_MODHIT: inc[i] = {1'b0, ev_rfo_modhit}; // [R02]
        EV_IO_READ: begin
          if (cfg[i].umask == UMASK_ANY) begin
            inc[i] = {1'b0, ev_io_any}; // [R03]
          end else if (cfg[i].umask == UMASK_SELF) begin
            inc[i] = {1'b0, ev_io_self}; // [R03]
          end
        end
        EV_PARTIAL_READ: inc[i] = {1'b0, ev_partial}; // [R04]
        EV_SNOOP_TOTAL: begin
          if (cfg[i].umask == UMASK_ANY) begin
            inc[i] = {1'b0, ev_snoop}; // [R05]
          end
        end
        EV_SNOOP_MODHIT: begin
          if (cfg[i].umask == UMASK_ANY) begin
            inc[i] = {1'b0, ev_snoop_hit}; // [R06]
          end
        end
        EV_SNOOP_STALL: begin
          if (cfg[i].umask == UMASK_ANY) begin
            inc[i] = {1'b0, ev_stall_any}; // [R08]
          end else if (cfg[i].umask == UMASK_SELF) begin
            inc[i] = {1'b0, ev_stall_self}; // [R08]
          end
        end
        EV_SNOOP_PENDING: begin
          if (i < PEND_CNT_LIMIT) begin
            inc[i] = pending; // [R09]
          end
        end
        EV_LINE_WRITEBACK: inc[i] = {1'b0, ev_writeback}; // [R11]
        EV_PRIVILEGE_CHANGE: inc[i] = {1'b0, ev_priv}; // [R12]
        EV_CPU_CYCLES: inc[i] = 2'h1; // [R13]
        EV_DATA_ACCESS: inc[i] = {1'b0, ev_data_stall}; // [R14]
        EV_DATA_CAPTURE: inc[i] = {1'b0, core_ev.capture_evt}; // [R15]
        EV_DATA_REFS: inc[i] = ev_refs; // [R16]
        EV_DEPENDENCY: inc[i] = {1'b0, ev_dep}; // [R17]
        default: inc[i] = 2'h0; // [R19]
      endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        cfg[i] <= bcem_cfg_t'(CFG_RST[12:0]);
      end else if (wr_pend && wr_addr == CFG_BASE + 8'(4 * i)) begin
        cfg[i].code <= hwdata[CFG_CODE_LSB +: 8];
        cfg[i].umask <= hwdata[CFG_UMASK_LSB +: 4];
        cfg[i].en <= hwdata[CFG_EN_BIT];
      end
    end

    // A software write wins over a same-cycle increment; the lost event is
    // at most a few counts and keeps the written value exact.
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        cnt[i] <= CNT_RST;
      end else if (wr_pend && wr_addr == CNT_BASE + 8'(4 * i)) begin
        cnt[i] <= hwdata;
      end else if (cfg[i].en) begin
        cnt[i] <= cnt[i] + {30'h0, inc[i]}; // [R19]
      end
    end
  end

endmodule

// ===== sim/bcem_monitor_sva.sv
// Checker for the event monitor register port, bound to the top module.
// Assumes hready is fed back from hreadyout and one clock domain.
`timescale 1ns/1ps
module bcem_monitor_sva
  import bcem_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire bcem_fsb_ev_t fsb_ev,
  input wire bcem_core_ev_t core_ev
);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  logic rd, wr, wpend;
  logic [1:0] widx, pend;
  logic [3:0] pcnt;
  logic [31:0] cfg_sh [4];
  assign rd = hsel && htrans[1] && hready && !hwrite;
  assign wr = hsel && htrans[1] && hready && hwrite && hsize == HSIZE_WORD && haddr[31:4] == 28'h0
    && haddr[1:0] == 2'h0;
  assign pcnt = 4'($countones(fsb_ev.sq_valid & ~fsb_ev.sq_snoop_done));
  assign pend = (pcnt > 4'h3) ? PENDING_MAX : pcnt[1:0];
  // The shadow lags a bypassed read, so a read in the write's data phase is not judged.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wpend <= 1'b0;
      widx <= 2'h0;
      cfg_sh <= '{default: CFG_RST};
    end else begin
      wpend <= wr;
      widx <= haddr[3:2];
      if (wpend) begin
        cfg_sh[widx] <= hwdata & CFG_MASK;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_ready_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_unmapped_zero: assert property (rd && haddr[31:2] > 30'h8 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_cfg_fields: assert property (rd && haddr < 32'h10 |=> (hrdata & ~CFG_MASK) == 32'h0)
    else $error("config reserved bits set");
  a_cfg_readback: assert property (rd && haddr < 32'h10 && !wpend |=> hrdata == $past(cfg_sh[haddr[3:2]]))
    else $error("config readback wrong");
  a_status_priv: assert property (rd && haddr == 32'h20 && $stable(core_ev.priv_level)
    |=> hrdata[1:0] == $past(core_ev.priv_level)) else $error("status privilege wrong");
  a_status_pend: assert property (rd && haddr == 32'h20 && $stable(fsb_ev.sq_valid)
    && $stable(fsb_ev.sq_snoop_done) |=> hrdata[9:8] == $past(pend)) else $error("status pending wrong");
  a_status_rsvd: assert property (rd && haddr == 32'h20 |=> hrdata[31:10] == 22'h0 && hrdata[7:2] == 6'h0)
    else $error("status reserved bits set");
  a_rdata_stands: assert property (!rd |=> $stable(hrdata))
    else $error("read data moved without a read");
  c_status: cover property (rd && haddr == 32'h20);
  c_cfg_write: cover property (wr);
  c_unmapped: cover property (rd && haddr[31:2] > 30'h8);
endmodule

// ===== sim/bcem_evt_src.sv
// Event source standing in for the core pipeline and bus unit.
// Assumes drive() is called right after a rising clock edge.
`timescale 1ns/1ps
module bcem_evt_src
  import bcem_pkg::*;
(
  input wire logic clk,
  output bcem_fsb_ev_t fsb_ev,
  output bcem_core_ev_t core_ev
);
  initial begin
    fsb_ev = '0;
    core_ev = '0;
  end
  // A held pattern repeats its events each cycle, up to 3 counts a cycle for pending snoops.
  // Two quiet cycles let a privilege return settle before the next read.
  task automatic drive(input logic [27:0] f, input logic [15:0] c, input int n);
    fsb_ev <= f;
    core_ev <= c;
    repeat (n) @(posedge clk);
    fsb_ev <= '0;
    core_ev <= '0;
    repeat (2) @(posedge clk);
  endtask
endmodule

// ===== sim/testbench.sv
// Self-checking bench for the event monitor: bus tasks and one task a scenario.
// Assumes the partner model drives all event inputs.
`timescale 1ns/1ps
module testbench;
  import bcem_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic hreadyout, hresp;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = HSIZE_WORD;
  logic [2:0] sz = HSIZE_WORD;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] cyc = 32'h0;
  logic [31:0] t_rd = 32'h0;
  logic [31:0] hrdata;
  int mismatches = 0;
  int checked = 0;
  bcem_fsb_ev_t fsb_ev;
  bcem_core_ev_t core_ev;
  always #50 clk = ~clk;
  bcem_monitor bcem_monitor_i (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .fsb_ev(fsb_ev), .core_ev(core_ev));
  bcem_evt_src bcem_evt_src_i (.clk(clk), .fsb_ev(fsb_ev), .core_ev(core_ev));
  // ---------------------------------------------------------------
  // Bus tasks
  // ---------------------------------------------------------------
  task chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("Error at %0t: got %h, expected %h", $time, s, e);
    end
  endtask
  task automatic ap(input logic [31:0] a, input logic w);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    hsize <= sz;
    do @(posedge clk); while (hreadyout !== 1'b1);
    t_rd = cyc;
    hsel <= 1'b0;
    htrans <= 2'h0;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    ap(a, 1'b1);
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    ap(a, 1'b0);
    do @(posedge clk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic regs();
    logic [31:0] v;
    for (int i = 0; i < 10; i++) begin
      rd(4 * i, v);
      chk(v, 32'h0);
    end
    wr(32'h24, '1);
    rd(32'h24, v);
    chk(v, 32'h0);
    wr(32'h20, '1);
    rd(32'h20, v);
    chk(v, 32'h0);
    wr(32'h04, '1);
    rd(32'h04, v);
    chk(v, CFG_MASK);
    sz = 3'h0;
    wr(32'h08, '1);
    sz = HSIZE_WORD;
    rd(32'h08, v);
    chk(v, 32'h0);
    wr(32'h14, 32'h89AB_CDEF);
    rd(32'h14, v);
    chk(v, 32'h89AB_CDEF);
    wr(32'h04, 32'h0);
    $display("register test done");
  endtask
  task automatic cycles();
    logic [31:0] a, b, t;
    wr(32'h0C, {15'h0, 1'b1, 8'h0, EV_CPU_CYCLES});
    rd(32'h1C, a);
    t = t_rd;
    repeat (5) @(posedge clk);
    rd(32'h1C, b);
    chk(b - a, t_rd - t);
    wr(32'h0C, 32'h0);
    rd(32'h1C, a);
    repeat (3) @(posedge clk);
    rd(32'h1C, b);
    chk(b - a, 32'h0);
    $display("cycle test done");
  endtask
  task automatic ev(input int n, input logic [7:0] code, input logic [3:0] um, input logic [27:0] f,
    input logic [15:0] c, input logic [31:0] e);
    logic [31:0] a, b;
    wr(4 * n, {15'h0, 1'b1, 4'h0, um, code});
    rd(32'h10 + 4 * n, a);
    bcem_evt_src_i.drive(f, c, 4);
    rd(32'h10 + 4 * n, b);
    wr(4 * n, 32'h0);
    chk(b - a, e);
    $display("event %h on counter %0d done", code, n + FIRST_CNT);
  endtask
  task end_of_test();
    $display("Checks %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Main sequence and hang guard
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 32'h1;
    if (cyc == 32'hFA0) begin
      mismatches++;
      end_of_test();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    regs();
    cycles();
    ev(0,8'h42,4'h5,28'h9C00000,16'h0,4);
    ev(0,8'h42,4'h0,28'h9400000,16'h0,0);
    ev(0,8'h43,4'h0,28'hAC00000,16'h0,4);
    ev(0,8'h43,4'h0,28'hA400000,16'h0,0);
    ev(1,8'h51,4'h0,28'hB000000,16'h0,4);
    ev(1,8'h51,4'h1,28'hB800000,16'h0,4);
    ev(1,8'h51,4'h1,28'hB000000,16'h0,0);
    ev(1,8'h51,4'h2,28'hB800000,16'h0,0);
    ev(1,8'h4D,4'h0,28'hC000000,16'h0,4);
    ev(0,8'h46,4'h0,28'h0100000,16'h0,4);
    ev(0,8'h46,4'h1,28'h0100000,16'h0,0);
    ev(0,8'h45,4'h0,28'h0180000,16'h0,4);
    ev(0,8'h45,4'h0,28'h0100000,16'h0,0);
    ev(2,8'h55,4'h0,28'h0060000,16'h0,4);
    ev(2,8'h55,4'h1,28'h0060000,16'h0,0);
    ev(2,8'h55,4'h1,28'h0070000,16'h0,4);
    ev(0,8'h56,4'h0,28'h0000F03,16'h0,8);
    ev(1,8'h56,4'h0,28'h000FF00,16'h0,12);
    ev(2,8'h56,4'h0,28'h000FF00,16'h0,0);
    ev(3,8'h52,4'h0,28'hD200000,16'h0,4);
    ev(3,8'h34,4'h0,28'h0,16'h8000,2);
    for (int i = 11; i < 14; i++) ev(3,8'h03,4'h0,28'h0,16'(1 << i),4);
    ev(0,8'h67,4'h0,28'h0,16'h0400,4);
    ev(0,8'h63,4'h0,28'h0,16'h0340,4);
    ev(0,8'h63,4'h0,28'h0,16'h03C0,8);
    for (int i = 1; i < 6; i++) ev(1,8'h06,4'h0,28'h0,16'(1 << i),4);
    ev(1,8'h06,4'h0,28'h0,16'h0021,0);
    ev(2,8'h7F,4'h0,28'h9C60000,16'h3FFE,0);
    end_of_test();
  end
endmodule
bind bcem_monitor bcem_monitor_sva bcem_monitor_sva_i (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .fsb_ev(fsb_ev), .core_ev(core_ev));
